// *** ppc_mgmt_model.sv ***
// station manager model driving the management strobes
`timescale 1ns/10ps
`default_nettype none
module ppc_mgmt_model (
   input wire logic mclk, // clock
   output logic [2:0] mgmt_port, // port select
   output logic [4:0] mgmt_reg, // register select
   output logic mgmt_wr, // write strobe
   output logic mgmt_rd, // read strobe
   output logic [15:0] mgmt_wdata // write data
);
   initial begin
      {mgmt_port, mgmt_reg, mgmt_wr, mgmt_rd, mgmt_wdata} = 26'h0;
   end
   task automatic xfer(input logic w, input logic [2:0] p, input logic [4:0] r,
                       input logic [15:0] d);
      @(negedge mclk);
      mgmt_port = p;
      mgmt_reg = r;
      mgmt_wr = w;
      mgmt_rd = !w;
      // unsupported codec and jam modes always written as 0
      mgmt_wdata = (r == ppc_pkg::REG_FAST) ? (d & 16'hffbb) : d;
      @(negedge mclk);
      mgmt_wr = 1'b0;
      mgmt_rd = 1'b0;
      // released lines flip so stale values never pass for held ones
      mgmt_wdata = ~mgmt_wdata;
      mgmt_reg = ~mgmt_reg;
      mgmt_port = ~mgmt_port;
   endtask
endmodule
`default_nettype wire

// *** ppc_pkg.sv ***
// package: register map, field positions, reset values and timing for port control
package ppc_pkg;
   localparam int unsigned NUM_PORTS = 8;
   localparam logic [4:0] REG_FAST = 5'h1d;
   localparam logic [4:0] REG_SLOW = 5'h1e;
   // fast path control fields
   localparam int unsigned F_PACKET_ERROR_REPORT_EN = 8;
   localparam int unsigned F_STRETCH = 7;
   localparam int unsigned F_CODEC = 6;
   localparam int unsigned F_ALIGN = 5;
   localparam int unsigned F_SCRAM = 4;
   localparam int unsigned F_CARIN = 3;
   localparam int unsigned F_JAM = 2;
   localparam int unsigned F_FEF = 1;
   localparam int unsigned F_FIBER = 0;
   // slow path control fields
   localparam int unsigned S_TXTEST = 15;
   localparam int unsigned S_LOWPWR = 14;
   localparam int unsigned S_JABBER = 13;
   localparam int unsigned S_LINK = 6;
   localparam int unsigned S_HBT = 5;
   localparam int unsigned S_LONG = 4;
   localparam int unsigned S_POLFIX = 3;
   localparam int unsigned S_RSVD = 2;
   localparam int unsigned S_SERIAL = 1;
   localparam int unsigned S_NOLP = 0;
   localparam logic [8:0] FAST_RESET = 9'h001;
   localparam logic [15:0] SLOW_RESET = 16'h0000;
   localparam logic [15:0] FAST_RD_MASK = 16'h01ff;
   localparam logic [15:0] SLOW_RD_MASK = 16'he07f;
   localparam logic [1:0] RXD_UNLOCKED_CODE = 2'h2;
   // led stretch window, nominal 42 ms at 125 MHz
   localparam int unsigned STRETCH_MS = 42;
   localparam int unsigned CLK_KHZ = 125000;
   localparam int unsigned STRETCH_CYCLES = STRETCH_MS * CLK_KHZ;
   // 10 MHz tx test: toggle enable every 6 or 7 cycles approximated by 6
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned TXTEST_MHZ = 10;
   localparam int unsigned TXTEST_HALF = CLK_MHZ / (2 * TXTEST_MHZ);
   typedef struct packed {
      logic scramble_bypass;
      logic symbol_align_bypass;
      logic carrier_integrity_en;
      logic far_end_fault_en;
      logic fiber_mode;
      logic tp_mode_en;
      logic low_power_disable;
      logic jabber_off;
      logic enhanced_link_integrity;
      logic heartbeat_en;
      logic long_line_squelch;
      logic polarity_fix_en;
      logic serial_mode;
      logic no_link_pulse_mode;
   } ppc_cfg_t;
   typedef struct packed {
      logic scramble_bypass;
      logic carrier_integrity_en;
      logic fiber_mode_strap;
      logic enhanced_link_integrity;
   } ppc_strap_t;
endpackage

// *** ppc_regs.sv ***
// per-port control registers for eight channels, with derived settings
`timescale 1ns/10ps
`default_nettype none
// Operation
// - packet error code on receive data when enabled
// - stretch activity and collision leds
// - aligner bypass disables symbol alignment
// - scramble bypass is register or strap
// - carrier integrity is register or strap
// - far-end fault enable, reset zero
// - fiber mode register or strap, resets one
// - transmit test sends ones at 10 MHz in slow mode while the slow path is powered
// - low-power disable keeps slow logic powered while link is up
// - jabber off disables jabber
// - enhanced link integrity register or strap
// - heartbeat enable in slow mode only
// - long line selects reduced squelch in slow mode only
// - autopolarity corrects reversal in slow mode unless disabled
// - read-only polarity corrected flag
// - serial select ignored at fast speed
// - no link pulse ignored at fast speed
module ppc_regs #(
   parameter int unsigned STRETCH_CYCLES = ppc_pkg::STRETCH_CYCLES
) (
   input wire logic mclk, // port clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic [2:0] mgmt_port, // management port address
   input wire logic [4:0] mgmt_reg, // management register address
   input wire logic mgmt_wr, // write strobe
   input wire logic mgmt_rd, // read strobe
   input wire logic [15:0] mgmt_wdata, // write data
   output logic [15:0] mgmt_rdata, // read data, one cycle after strobe
   output logic mgmt_rvalid, // read data valid pulse
   input wire logic [7:0] strap_scramble_bypass, // strap pins
   input wire logic [7:0] strap_carrier_integrity, // strap pins
   input wire logic [7:0] fiber_mode_strap, // strap pins
   input wire logic [7:0] strap_enhanced_link, // strap pins
   input wire logic [7:0] speed_100, // per-port speed, same domain
   input wire logic [7:0] link_up, // per-port link status, same domain
   input wire logic [7:0] rx_active, // per-port receive activity
   input wire logic [7:0] polarity_reversed, // reversal detected
   input wire logic [7:0] rx_err_in, // receive error request
   input wire logic [7:0] activity_raw, // raw activity indicator
   input wire logic [7:0] collision_raw, // raw collision indicator
   output logic [7:0] receive_error_out, // receive error to mac
   output logic [15:0] rxd_error_code, // 2 bits per port
   output logic [7:0] activity_led, // stretched activity
   output logic [7:0] collision_led, // stretched collision
   output logic [7:0] slow_tx_test_pattern, // 10 MHz ones pattern
   output logic [7:0] slow_powered, // slow path power enable
   output logic [7:0] polarity_invert, // polarity correction applied
   output logic [7:0] polarity_corrected_flag, // status flag
   output ppc_pkg::ppc_cfg_t [7:0] cfg // per-port settings
);
   // ------------------------------------------------------------
   // strap synchronisers
   // ------------------------------------------------------------
   ppc_pkg::ppc_strap_t [7:0] strap_meta;
   ppc_pkg::ppc_strap_t [7:0] strap_sync;
   ppc_pkg::ppc_strap_t [7:0] strap_raw;
   logic [8:0] fast [8];
   logic [15:0] slow [8];
   logic [8:0] next_fast [8];
   logic [15:0] next_slow [8];
   logic [15:0] next_rdata;
   logic [7:0] act_str;
   logic [7:0] col_str;
   logic [3:0] tx_div;
   logic [3:0] next_tx_div;
   logic tx_tick;
   ppc_pkg::ppc_cfg_t [7:0] next_cfg;
   logic [7:0] next_rx_err;
   logic [15:0] next_code;
   logic [7:0] next_test;
   logic [7:0] next_power;
   logic [7:0] next_invert;
   logic [7:0] next_polflag;

   always_comb begin
      for (int p = 0; p < 8; p++) begin
         strap_raw[p].scramble_bypass = strap_scramble_bypass[p];
         strap_raw[p].carrier_integrity_en = strap_carrier_integrity[p];
         strap_raw[p].fiber_mode_strap = fiber_mode_strap[p];
         strap_raw[p].enhanced_link_integrity = strap_enhanced_link[p];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         strap_meta <= '0;
         strap_sync <= '0;
      end else begin
         strap_meta <= strap_raw;
         strap_sync <= strap_meta;
      end
   end

   // ------------------------------------------------------------
   // register write path
   // ------------------------------------------------------------
   always_comb begin
      for (int p = 0; p < 8; p++) begin
         next_fast[p] = fast[p];
         next_slow[p] = slow[p];
         if (mgmt_wr && (mgmt_port == 3'(p))) begin
            if (mgmt_reg == ppc_pkg::REG_FAST) begin
               next_fast[p] = mgmt_wdata[8:0];
            end
            if (mgmt_reg == ppc_pkg::REG_SLOW) begin
               // unused field not stored, reserved bit kept
               next_slow[p] = mgmt_wdata & ppc_pkg::SLOW_RD_MASK;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      for (int p = 0; p < 8; p++) begin
         if (!rst_n) begin
            fast[p] <= ppc_pkg::FAST_RESET;
            slow[p] <= ppc_pkg::SLOW_RESET;
         end else begin
            fast[p] <= next_fast[p];
            slow[p] <= next_slow[p];
         end
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   always_comb begin
      next_rdata = 16'h0000;
      if (mgmt_rd) begin
         if (mgmt_reg == ppc_pkg::REG_FAST) begin
            next_rdata = {7'h00, fast[mgmt_port]};
         end else if (mgmt_reg == ppc_pkg::REG_SLOW) begin
            next_rdata = slow[mgmt_port];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mgmt_rdata <= 16'h0000;
         mgmt_rvalid <= 1'b0;
      end else begin
         mgmt_rdata <= next_rdata;
         mgmt_rvalid <= mgmt_rd;
      end
   end

   // ------------------------------------------------------------
   // 10 MHz test divider
   // ------------------------------------------------------------
   always_comb begin
      tx_tick = (tx_div == 4'(ppc_pkg::TXTEST_HALF - 1));
      next_tx_div = tx_tick ? 4'h0 : tx_div + 4'h1;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tx_div <= 4'h0;
      end else begin
         tx_div <= next_tx_div;
      end
   end

   // ------------------------------------------------------------
   // per-port derived settings
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_port
         ppc_stretch #(.CYCLES(STRETCH_CYCLES)) u_act (
            .mclk(mclk),
            .rst_n(rst_n),
            .en(fast[g][ppc_pkg::F_STRETCH]),
            .raw(activity_raw[g]),
            .led(act_str[g])
         );
         ppc_stretch #(.CYCLES(STRETCH_CYCLES)) u_col (
            .mclk(mclk),
            .rst_n(rst_n),
            .en(fast[g][ppc_pkg::F_STRETCH]),
            .raw(collision_raw[g]),
            .led(col_str[g])
         );
      end
   endgenerate

   always_comb begin
      for (int p = 0; p < 8; p++) begin
         logic fib;
         logic slow_mode;
         fib = fast[p][ppc_pkg::F_FIBER] | strap_sync[p].fiber_mode_strap;
         slow_mode = !speed_100[p] && !fib;
         next_cfg[p].fiber_mode = fib;
         next_cfg[p].tp_mode_en = !fib;
         next_cfg[p].scramble_bypass =
            fast[p][ppc_pkg::F_SCRAM] | strap_sync[p].scramble_bypass;
         next_cfg[p].symbol_align_bypass = fast[p][ppc_pkg::F_ALIGN];
         next_cfg[p].carrier_integrity_en =
            fast[p][ppc_pkg::F_CARIN] | strap_sync[p].carrier_integrity_en;
         next_cfg[p].far_end_fault_en = fast[p][ppc_pkg::F_FEF];
         next_cfg[p].low_power_disable = slow[p][ppc_pkg::S_LOWPWR];
         next_cfg[p].jabber_off = slow[p][ppc_pkg::S_JABBER];
         next_cfg[p].enhanced_link_integrity =
            slow[p][ppc_pkg::S_LINK] | strap_sync[p].enhanced_link_integrity;
         next_cfg[p].heartbeat_en = slow[p][ppc_pkg::S_HBT] && slow_mode;
         next_cfg[p].long_line_squelch = slow[p][ppc_pkg::S_LONG] && slow_mode;
         next_cfg[p].polarity_fix_en = !slow[p][ppc_pkg::S_POLFIX] && slow_mode;
         next_cfg[p].serial_mode = slow[p][ppc_pkg::S_SERIAL] && slow_mode;
         next_cfg[p].no_link_pulse_mode = slow[p][ppc_pkg::S_NOLP] && slow_mode;
         // unlocked code only reported with the error strobe
         next_rx_err[p] = rx_err_in[p];
         next_code[2 * p +: 2] = (rx_err_in[p] && fast[p][ppc_pkg::F_PACKET_ERROR_REPORT_EN]) ?
            ppc_pkg::RXD_UNLOCKED_CODE : 2'h0;
         next_power[p] = (slow[p][ppc_pkg::S_LOWPWR] && link_up[p]) || rx_active[p];
         // test pattern runs only while slow path is powered
         next_test[p] = slow[p][ppc_pkg::S_TXTEST] && slow_mode && next_power[p] ?
            (tx_tick ? !slow_tx_test_pattern[p] : slow_tx_test_pattern[p]) : 1'b0;
         next_invert[p] = polarity_reversed[p] && next_cfg[p].polarity_fix_en;
         next_polflag[p] = next_invert[p];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cfg <= '0;
         receive_error_out <= 8'h00;
         rxd_error_code <= 16'h0000;
         activity_led <= 8'h00;
         collision_led <= 8'h00;
         slow_tx_test_pattern <= 8'h00;
         slow_powered <= 8'h00;
         polarity_invert <= 8'h00;
         polarity_corrected_flag <= 8'h00;
      end else begin
         cfg <= next_cfg;
         receive_error_out <= next_rx_err;
         rxd_error_code <= next_code;
         activity_led <= act_str;
         collision_led <= col_str;
         slow_tx_test_pattern <= next_test;
         slow_powered <= next_power;
         polarity_invert <= next_invert;
         polarity_corrected_flag <= next_polflag;
      end
   end
endmodule
`default_nettype wire

// *** ppc_regs_asserts.sv ***
// concurrent checks on the port control register outputs
`timescale 1ns/10ps
`default_nettype none
module ppc_regs_asserts (
   input wire logic mclk, // clock
   input wire logic rst_n, // reset
   input wire logic mgmt_rd, // read strobe
   input wire logic mgmt_rvalid, // read valid
   input wire logic [7:0] rx_err_in, // error request
   input wire logic [7:0] receive_error_out, // error out
   input wire logic [15:0] rxd_error_code, // error codes
   input wire logic [7:0] fiber_mode_strap, // strap
   input wire logic [7:0] speed_100, // speed
   input wire logic [7:0] link_up, // link
   input wire logic [7:0] rx_active, // rx busy
   input wire logic [7:0] polarity_reversed, // reversal seen
   input wire logic [7:0] polarity_invert, // correction
   input wire logic [7:0] polarity_corrected_flag, // status
   input wire logic [7:0] slow_powered, // power
   input wire logic [7:0] slow_tx_test_pattern, // test tone
   input wire ppc_pkg::ppc_cfg_t [7:0] cfg // settings
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   chk_read_answer: assert property (mgmt_rd |=> mgmt_rvalid)
      else $error("read not answered");
   chk_read_cause: assert property (mgmt_rvalid |-> $past(mgmt_rd))
      else $error("read valid without strobe");
   chk_err_delay: assert property ($past(rst_n) |-> receive_error_out == $past(rx_err_in))
      else $error("error output not one cycle late");
   chk_err_code: assert property (rxd_error_code[1:0] != 2'h0 |->
      rxd_error_code[1:0] == 2'h2 && receive_error_out[0])
      else $error("bad error code");
   chk_fiber_strap: assert property (fiber_mode_strap[0] [*4] |->
      cfg[0].fiber_mode && !cfg[0].tp_mode_en)
      else $error("fiber strap ignored");
   chk_fiber_tp: assert property ($past(rst_n) |-> cfg[0].fiber_mode != cfg[0].tp_mode_en)
      else $error("fiber and twisted pair clash");
   chk_pol_flag: assert property (polarity_corrected_flag[0] |->
      $past(polarity_reversed[0]) && polarity_invert[0])
      else $error("polarity flag without reversal");
   chk_power_rx: assert property ($past(rst_n) && $past(rx_active[0]) |-> slow_powered[0])
      else $error("slow path off while receiving");
   chk_power_idle: assert property ($past(rst_n) && !$past(link_up[0]) && !$past(rx_active[0])
      |-> !slow_powered[0])
      else $error("slow path on while idle");
   chk_fast_tx: assert property (speed_100[0] [*3] |=> !slow_tx_test_pattern[0])
      else $error("test tone at fast speed");
   chk_fast_serial: assert property (speed_100[0] [*3] |=>
      !cfg[0].serial_mode && !cfg[0].no_link_pulse_mode)
      else $error("slow-only setting at fast speed");
endmodule
bind ppc_regs ppc_regs_asserts chk_i (.*);
`default_nettype wire

// *** ppc_regs_test.sv ***
// self-checking bench for the per-port control registers
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
   $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module ppc_regs_test;
   logic mclk, rst_n, mgmt_wr, mgmt_rd, mgmt_rvalid;
   logic [2:0] mgmt_port;
   logic [4:0] mgmt_reg;
   logic [15:0] mgmt_wdata, mgmt_rdata, rxd_error_code, exp_r;
   logic [7:0] strap_scramble_bypass, strap_carrier_integrity, fiber_mode_strap;
   logic [7:0] strap_enhanced_link, speed_100, link_up, rx_active, polarity_reversed;
   logic [7:0] rx_err_in, activity_raw, collision_raw, receive_error_out, activity_led;
   logic [7:0] collision_led, slow_tx_test_pattern, slow_powered, polarity_invert;
   logic [7:0] polarity_corrected_flag;
   ppc_pkg::ppc_cfg_t [7:0] cfg;
   logic [15:0] exp_q[$];
   logic [15:0] wd [16];
   int fails, checked, cycles, seed, i;
   logic [3:0] ones;
   ppc_regs #(.STRETCH_CYCLES(20)) DUT (.*);
   ppc_mgmt_model bus (.*);
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic tally_and_finish();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic rd(input logic [2:0] p, input logic [4:0] r, input logic [15:0] e);
      exp_q.push_back(e);
      bus.xfer(1'b0, p, r, 16'h0);
   endtask
   task automatic wr(input logic [4:0] r, input logic [15:0] d, input int n);
      bus.xfer(1'b1, 3'h0, r, d);
      repeat (n) @(negedge mclk);
   endtask
   // read results are matched against the oldest note
   always @(negedge mclk) begin
      cycles++;
      if (cycles > 2000) begin
         fails++;
         tally_and_finish();
      end else if (mgmt_rvalid === 1'b1) begin
         exp_r = exp_q.pop_front();
         `CHK(mgmt_rdata, exp_r)
      end
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      seed = 93;
      {fails, checked, cycles} = 96'h0;
      rst_n = 1'b0;
      {strap_scramble_bypass, strap_carrier_integrity, fiber_mode_strap} = 24'h0;
      {strap_enhanced_link, speed_100, link_up, polarity_reversed} = 32'h0;
      {rx_err_in, activity_raw, collision_raw} = 24'h0;
      rx_active = 8'($random(seed)) & 8'hfe;
      repeat (3) @(negedge mclk);
      rst_n = 1'b1;
      for (i = 0; i < 8; i++) begin
         rd(i[2:0], ppc_pkg::REG_FAST, 16'h0001);
         rd(i[2:0], ppc_pkg::REG_SLOW, 16'h0000);
      end
      wr(ppc_pkg::REG_FAST, 16'h0000, 2);
      {strap_scramble_bypass, strap_carrier_integrity, fiber_mode_strap} = 24'h010101;
      strap_enhanced_link = 8'h01;
      repeat (5) @(negedge mclk);
      `CHK({cfg[0][13], cfg[0][11], cfg[0][9:8], cfg[0][5]}, 5'b11101)
      {strap_scramble_bypass, strap_carrier_integrity, fiber_mode_strap} = 24'h0;
      strap_enhanced_link = 8'h00;
      repeat (5) @(negedge mclk);
      `CHK(cfg[0][13:5], 9'h008)
      // channels hold independent copies; codec and jam bits masked by the manager
      for (i = 0; i < 16; i++) wd[i] = 16'($random(seed));
      for (i = 0; i < 16; i++)
         bus.xfer(1'b1, i[3:1], i[0] ? ppc_pkg::REG_SLOW : ppc_pkg::REG_FAST, wd[i]);
      for (i = 0; i < 16; i++)
         rd(i[3:1], i[0] ? ppc_pkg::REG_SLOW : ppc_pkg::REG_FAST,
            wd[i] & (i[0] ? 16'he07f : 16'h01bb));
      rd(3'h2, 5'h1f, 16'h0000);
      wr(ppc_pkg::REG_FAST, 16'h003a, 2);
      `CHK(cfg[0][13:8], 6'h3d)
      wr(ppc_pkg::REG_SLOW, 16'h607b, 2);
      `CHK(cfg[0][7:0], 8'hfb)
      speed_100 = 8'h01;
      repeat (4) @(negedge mclk);
      `CHK(cfg[0][4:0], 5'h00)
      speed_100 = 8'h00;
      polarity_reversed = 8'h01;
      wr(ppc_pkg::REG_SLOW, 16'h0000, 3);
      `CHK({polarity_corrected_flag[0], polarity_invert[0]}, 2'b11)
      wr(ppc_pkg::REG_SLOW, 16'h0008, 3);
      `CHK({polarity_corrected_flag[0], polarity_invert[0]}, 2'b00)
      polarity_reversed = 8'h00;
      for (i = 0; i < 2; i++) begin
         wr(ppc_pkg::REG_FAST, i[0] ? 16'h0000 : 16'h0100, 2);
         rx_err_in = 8'h01;
         @(negedge mclk);
         `CHK({receive_error_out[0], rxd_error_code[1:0]}, i[0] ? 3'b100 : 3'b110)
         rx_err_in = 8'h00;
      end
      // stretch window is 20 cycles in this bench
      for (i = 0; i < 2; i++) begin
         wr(ppc_pkg::REG_FAST, i[0] ? 16'h0000 : 16'h0080, 24);
         {activity_raw, collision_raw} = 16'h0101;
         @(negedge mclk);
         {activity_raw, collision_raw} = 16'h0000;
         repeat (12) @(negedge mclk);
         `CHK({activity_led[0], collision_led[0]}, i[0] ? 2'b00 : 2'b11)
      end
      link_up = 8'h01;
      wr(ppc_pkg::REG_SLOW, 16'h4000, 3);
      `CHK(slow_powered[0], 1'b1)
      // one full test period holds exactly one half period of highs
      wr(ppc_pkg::REG_SLOW, 16'hc000, 2);
      ones = 4'h0;
      repeat (2 * ppc_pkg::TXTEST_HALF) begin
         @(negedge mclk);
         ones = ones + {3'h0, slow_tx_test_pattern[0]};
      end
      `CHK(ones, 4'(ppc_pkg::TXTEST_HALF))
      speed_100 = 8'h01;
      repeat (4) @(negedge mclk);
      `CHK(slow_tx_test_pattern[0], 1'b0)
      speed_100 = 8'h00;
      wr(ppc_pkg::REG_SLOW, 16'h8000, 3);
      `CHK(slow_tx_test_pattern[0], 1'b0)
      wr(ppc_pkg::REG_SLOW, 16'h0000, 3);
      `CHK(slow_powered[0], 1'b0)
      rx_active[0] = 1'b1;
      repeat (2) @(negedge mclk);
      `CHK(slow_powered[0], 1'b1)
      rx_active[0] = 1'b0;
      repeat (4) @(negedge mclk);
      tally_and_finish();
   end
endmodule
`default_nettype wire

// *** ppc_stretch.sv ***
// led pulse stretcher, holds an indicator for a programmable window
`timescale 1ns/10ps
`default_nettype none
module ppc_stretch #(
   parameter int unsigned CYCLES = ppc_pkg::STRETCH_CYCLES
) (
   input wire logic mclk, // port clock
   input wire logic rst_n, // synchronous reset
   input wire logic en, // stretching on
   input wire logic raw, // raw indicator
   output logic led // stretched indicator
);
   logic [23:0] cnt;
   logic [23:0] next_cnt;
   logic next_led;
   always_comb begin
      next_cnt = cnt;
      next_led = raw;
      if (en) begin
         // a fresh event restarts the window, so the led stays on for one window after the last event
         if (raw) begin
            next_cnt = 24'(CYCLES);
         end else if (cnt != 24'h000000) begin
            next_cnt = cnt - 24'h000001;
         end
         next_led = raw || (cnt != 24'h000000);
      end else begin
         next_cnt = 24'h000000;
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cnt <= 24'h000000;
         led <= 1'b0;
      end else begin
         cnt <= next_cnt;
         led <= next_led;
      end
   end
endmodule
`default_nettype wire
